// ### rtl/pcr_pkg.sv
// Package of register map, field positions and reset values for the power control register
package pcr_pkg;
    localparam logic [7:0] PCR_ADDR = 8'h87;
    localparam logic [7:0] PCR_RESET_VAL = 8'h10;
    localparam logic [7:0] PCR_UNMAPPED_VAL = 8'h00;
    localparam int PCR_BIT_DOZE = 0;
    localparam int PCR_BIT_DEEP_SLEEP = 1;
    localparam int PCR_BIT_USER_ZERO = 2;
    localparam int PCR_BIT_USER_ONE = 3;
    localparam int PCR_BIT_POWER_LOSS = 4;
    localparam int PCR_BIT_RESERVED = 5;
    localparam int PCR_BIT_FE_VIEW_SEL = 6;
    localparam int PCR_BIT_BAUD_DOUBLER = 7;
    localparam logic [1:0] PCR_SERIAL_MODE_ZERO = 2'h0;
endpackage : pcr_pkg

// ### rtl/pcr_mode_if.sv
// Interface carrying the mode and serial option bits from the register to the request logic
interface pcr_mode_if;
    logic doze_bit;
    logic deep_sleep_bit;
    logic baud_doubler;
    logic frame_error_view_select;

    modport src (
        output doze_bit,
        output deep_sleep_bit,
        output baud_doubler,
        output frame_error_view_select
    );

    modport ctl (
        input doze_bit,
        input deep_sleep_bit,
        input baud_doubler,
        input frame_error_view_select
    );
endinterface : pcr_mode_if

// ### rtl/pcr_mode_ctl.sv
// Registered power mode requests and serial option steering derived from the register bits
module pcr_mode_ctl
    import pcr_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Register bits
    pcr_mode_if.ctl mode,
    // Serial port side
    input wire logic [1:0] serial_mode,
    input wire logic serial_mode_bit_zero,
    input wire logic framing_error_flag,
    output logic serial_top_bit_view,
    output logic baud_x2_en,
    // Clock control side
    output logic idle_req,
    output logic pd_req
);
    logic idle_next;
    logic pd_next;
    logic view_next;
    logic x2_next;
    logic idle_reg;
    logic pd_reg;
    logic view_reg;
    logic x2_reg;

    // Deep sleep wins so the clock logic never sees two requests at once; reset drops everything
    always_comb begin
        pd_next = 1'b0;
        idle_next = 1'b0;
        view_next = 1'b0;
        x2_next = 1'b0;
        if (rst_n) begin
            pd_next = mode.deep_sleep_bit;
            idle_next = mode.doze_bit && !mode.deep_sleep_bit;
            view_next = mode.frame_error_view_select ? framing_error_flag : serial_mode_bit_zero;
            x2_next = mode.baud_doubler && (serial_mode != PCR_SERIAL_MODE_ZERO);
        end
    end

    // Outputs come from flip-flops, one cycle behind the register
    always_ff @(posedge clk_sys) begin
        pd_reg <= pd_next;
        idle_reg <= idle_next;
        view_reg <= view_next;
        x2_reg <= x2_next;
    end

    assign pd_req = pd_reg;
    assign idle_req = idle_reg;
    assign serial_top_bit_view = view_reg;
    assign baud_x2_en = x2_reg;

    a_baud_double_mode: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $past(rst_n) |-> baud_x2_en == $past(mode.baud_doubler && serial_mode != PCR_SERIAL_MODE_ZERO))
        else $error("baud doubling not following bit and mode");
    a_frame_view_route: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $past(rst_n) && $past(mode.frame_error_view_select) |-> serial_top_bit_view == $past(framing_error_flag))
        else $error("top serial bit not showing framing error");
    a_mode_req_exclusive: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $past(rst_n) |-> !(idle_req && pd_req) && (pd_req == $past(mode.deep_sleep_bit)))
        else $error("power down request wrong or overlapping idle");
endmodule : pcr_mode_ctl

// ### rtl/pcr_power_control.sv
// Power control register with power-loss flag, mode bits, user flags and serial options
// Summary of operation
// - Supply rise sets the power-loss flag.
// - Warm reset leaves power-loss flag unchanged.
// - Software may set or clear power-loss flag.
// - Deep-sleep bit enters power-down; reset clears it.
// - Doze bit enters idle; interrupt/reset clear it.
// - User flags are plain software storage.
// - View select routes serial top bit.
// - Reserved bit reads indeterminate; never write one. Here it is never kept and reads as zero.
// - Reset pattern 00X1 0000, byte access only.
// - Power-down left only by reset or wake interrupt. Here a register write that clears the deep-sleep bit also ends it.
module pcr_power_control
    import pcr_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Supply rise marker, held while rst_n is low after switch-on
    input wire logic supply_rise,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Interrupt events
    input wire logic irq_taken,
    input wire logic ext_level_wake,
    // Serial port side
    input wire logic [1:0] serial_mode,
    input wire logic serial_mode_bit_zero,
    input wire logic framing_error_flag,
    output logic serial_top_bit_view,
    output logic baud_x2_en,
    // Clock control side
    output logic idle_req,
    output logic pd_req
);
    logic [7:0] power_control_reg;
    logic [7:0] power_control_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic wr_hit;
    logic rd_hit;

    pcr_mode_if mode_bus ();

    // Whole-byte decode; the register is not bit addressable
    function automatic logic addr_hit(input logic [7:0] addr);
        return addr == PCR_ADDR;
    endfunction : addr_hit

    assign wr_hit = reg_wr && addr_hit(reg_addr);
    assign rd_hit = reg_rd && addr_hit(reg_addr);

    // Next register value: reset, hardware clears, then software write
    always_comb begin
        power_control_next = power_control_reg;
        if (!rst_n) begin
            // Every reset clears mode and option bits; the flag only changes on supply rise
            power_control_next = PCR_RESET_VAL;
            power_control_next[PCR_BIT_POWER_LOSS] = power_control_reg[PCR_BIT_POWER_LOSS] | supply_rise;
            power_control_next[PCR_BIT_DEEP_SLEEP] = 1'b0;
            power_control_next[PCR_BIT_DOZE] = 1'b0;
        end else begin
            // Hardware clears first so that a same-cycle software set wins
            if (irq_taken) begin
                power_control_next[PCR_BIT_DOZE] = 1'b0;
            end
            if (ext_level_wake) begin
                power_control_next[PCR_BIT_DEEP_SLEEP] = 1'b0;
            end
            if (wr_hit) begin
                power_control_next = reg_wdata;
                power_control_next[PCR_BIT_RESERVED] = 1'b0;
            end
        end
    end

    // Read data stand only in the cycle after the read strobe
    // Idle and unmapped cycles read as zero so a stray read never sees stale data
    always_comb begin
        rdata_next = PCR_UNMAPPED_VAL;
        if (rst_n && rd_hit) begin
            rdata_next = power_control_reg;
            rdata_next[PCR_BIT_RESERVED] = 1'b0;
        end
    end

    // Register stage; the flag is never forced by reset, only by supply rise
    // The synchronous reset lives in the next-value logic, so this stage only registers
    always_ff @(posedge clk_sys) begin
        power_control_reg <= power_control_next;
        rdata_reg <= rdata_next;
    end

    assign reg_rdata = rdata_reg;

    // Hand the bits to the request logic
    assign mode_bus.doze_bit = power_control_reg[PCR_BIT_DOZE];
    assign mode_bus.deep_sleep_bit = power_control_reg[PCR_BIT_DEEP_SLEEP];
    assign mode_bus.baud_doubler = power_control_reg[PCR_BIT_BAUD_DOUBLER];
    assign mode_bus.frame_error_view_select = power_control_reg[PCR_BIT_FE_VIEW_SEL];

    pcr_mode_ctl u_mode_ctl (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .mode(mode_bus),
        .serial_mode(serial_mode),
        .serial_mode_bit_zero(serial_mode_bit_zero),
        .framing_error_flag(framing_error_flag),
        .serial_top_bit_view(serial_top_bit_view),
        .baud_x2_en(baud_x2_en),
        .idle_req(idle_req),
        .pd_req(pd_req)
    );

    // Named steps of a register access
    sequence s_write_hit;
        rst_n && wr_hit;
    endsequence

    sequence s_read_hit;
        rst_n && rd_hit;
    endsequence

    // Steps of a mode request: the bit is written, then the request follows
    sequence s_doze_write;
        rst_n && wr_hit && reg_wdata[PCR_BIT_DOZE] && !reg_wdata[PCR_BIT_DEEP_SLEEP];
    endsequence

    sequence s_sleep_write;
        rst_n && wr_hit && reg_wdata[PCR_BIT_DEEP_SLEEP];
    endsequence

    // A wake event that clears deep sleep, and stray accesses that must not disturb the byte
    sequence s_wake_event;
        rst_n && ext_level_wake && !wr_hit;
    endsequence

    sequence s_unmapped_write;
        rst_n && reg_wr && !wr_hit && !irq_taken && !ext_level_wake;
    endsequence

    // Flag, reset and read checks
    a_cold_sets_flag: assert property (@(posedge clk_sys)
        !rst_n && supply_rise |=> power_control_reg[PCR_BIT_POWER_LOSS])
        else $error("supply rise did not set power-loss flag");
    a_warm_keeps_flag: assert property (@(posedge clk_sys)
        !rst_n && !supply_rise |=> $stable(power_control_reg[PCR_BIT_POWER_LOSS]))
        else $error("warm reset changed power-loss flag");
    a_sw_writes_flag: assert property (@(posedge clk_sys)
        s_write_hit |=> power_control_reg[PCR_BIT_POWER_LOSS] == $past(reg_wdata[PCR_BIT_POWER_LOSS]))
        else $error("software write to power-loss flag lost");
    a_reset_clears_sleep: assert property (@(posedge clk_sys)
        !rst_n |=> !power_control_reg[PCR_BIT_DEEP_SLEEP] ##1 !pd_req)
        else $error("reset did not clear deep sleep");
    a_irq_clears_doze: assert property (@(posedge clk_sys)
        rst_n && irq_taken && !wr_hit |=> !power_control_reg[PCR_BIT_DOZE] ##1 !idle_req)
        else $error("interrupt did not clear doze");
    a_user_flags_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !wr_hit && !irq_taken |=> $stable(power_control_reg[PCR_BIT_USER_ONE:PCR_BIT_USER_ZERO]))
        else $error("user flags changed without a write");
    a_resv_reads_zero: assert property (@(posedge clk_sys)
        s_read_hit |=> !reg_rdata[PCR_BIT_RESERVED])
        else $error("reserved bit not read as zero");
    a_read_whole_byte: assert property (@(posedge clk_sys)
        s_read_hit ##1 rst_n |-> reg_rdata == ($past(power_control_reg) & ~(8'h01 << PCR_BIT_RESERVED)))
        else $error("read data differ from register");
    a_pd_exit_only: assert property (@(posedge clk_sys) disable iff (!rst_n)
        power_control_reg[PCR_BIT_DEEP_SLEEP] && !ext_level_wake |=> power_control_reg[PCR_BIT_DEEP_SLEEP])
        else $error("power-down left without reset or wake");

    // Mode requests follow the bits two edges after the write
    a_sleep_write_req: assert property (@(posedge clk_sys)
        s_sleep_write ##1 rst_n |-> power_control_reg[PCR_BIT_DEEP_SLEEP] ##1 pd_req)
        else $error("deep sleep write did not raise power-down request");
    a_doze_write_req: assert property (@(posedge clk_sys)
        s_doze_write ##1 rst_n |-> power_control_reg[PCR_BIT_DOZE] ##1 idle_req)
        else $error("doze write did not raise idle request");
    a_reset_clears_doze: assert property (@(posedge clk_sys)
        !rst_n |=> !power_control_reg[PCR_BIT_DOZE] ##1 !idle_req)
        else $error("reset did not clear doze");
    a_wake_clears_sleep: assert property (@(posedge clk_sys)
        s_wake_event |=> !power_control_reg[PCR_BIT_DEEP_SLEEP])
        else $error("wake interrupt did not clear deep sleep");
    a_idle_follows_doze: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $past(rst_n) |->
            idle_req == $past(power_control_reg[PCR_BIT_DOZE] && !power_control_reg[PCR_BIT_DEEP_SLEEP]))
        else $error("idle request not following doze under deep sleep precedence");

    // Storage checks; the reserved bit is never kept, so its read value is settled
    a_user_flags_write: assert property (@(posedge clk_sys)
        s_write_hit |=> power_control_reg[PCR_BIT_USER_ONE:PCR_BIT_USER_ZERO] ==
            $past(reg_wdata[PCR_BIT_USER_ONE:PCR_BIT_USER_ZERO]))
        else $error("user flags did not take the written value");
    a_resv_never_kept: assert property (@(posedge clk_sys)
        rst_n |-> !power_control_reg[PCR_BIT_RESERVED])
        else $error("reserved bit held a one");
    a_reset_pattern: assert property (@(posedge clk_sys)
        !rst_n |=> ((power_control_reg ^ PCR_RESET_VAL) & ~(8'h01 << PCR_BIT_POWER_LOSS)) == 8'h00)
        else $error("reset pattern wrong outside the power-loss flag");

    // Stray addresses and idle cycles leave the port quiet
    a_unmapped_no_write: assert property (@(posedge clk_sys)
        s_unmapped_write |=> $stable(power_control_reg))
        else $error("write to another address changed the register");
    a_unmapped_read_zero: assert property (@(posedge clk_sys)
        rst_n && reg_rd && !rd_hit |=> reg_rdata == PCR_UNMAPPED_VAL)
        else $error("read of another address returned data");
    a_rdata_idle_zero: assert property (@(posedge clk_sys)
        !(rst_n && rd_hit) |=> reg_rdata == PCR_UNMAPPED_VAL)
        else $error("read data stood outside the cycle after a read");

    // Serial steering seen from the register side
    a_x2_off_mode_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $past(rst_n) && $past(serial_mode) == PCR_SERIAL_MODE_ZERO |-> !baud_x2_en)
        else $error("baud doubling active in serial mode zero");
    a_view_selects_mode: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $past(rst_n) && !$past(power_control_reg[PCR_BIT_FE_VIEW_SEL]) |->
            serial_top_bit_view == $past(serial_mode_bit_zero))
        else $error("top serial bit not showing mode bit zero");
endmodule : pcr_power_control

// ### verif/pcr_power_control_tb.sv
// Self-checking testbench for the power control register: byte access, reset kinds and mode requests
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module pcr_power_control_tb
    import pcr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic supply_rise = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic irq_taken = 1'b0;
    logic ext_level_wake = 1'b0;
    logic [1:0] serial_mode = 2'h1;
    logic serial_mode_bit_zero = 1'b1;
    logic framing_error_flag = 1'b0;
    logic serial_top_bit_view;
    logic baud_x2_en;
    logic idle_req;
    logic pd_req;
    int n_mismatch = 0;
    int compares = 0;

    // Clock at 125 MHz
    always #4 clk_sys = ~clk_sys;

    pcr_power_control u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .supply_rise(supply_rise), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_taken(irq_taken),
        .ext_level_wake(ext_level_wake), .serial_mode(serial_mode), .serial_mode_bit_zero(serial_mode_bit_zero),
        .framing_error_flag(framing_error_flag), .serial_top_bit_view(serial_top_bit_view),
        .baud_x2_en(baud_x2_en), .idle_req(idle_req), .pd_req(pd_req));

    // Counts and verdict; the only place the run ends
    task automatic end_sim();
        $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_sim

    // One-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr

    // Read data stands one cycle only, then must return to zero
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 `CHK(reg_rdata, exp)
        @(posedge clk_sys);
        #1 `CHK(reg_rdata, 8'h00)
    endtask : rd_chk

    // Reset for 20 cycles; cold marks a supply switch-on
    task automatic rst(input logic cold);
        @(posedge clk_sys);
        rst_n <= 1'b0;
        supply_rise <= cold;
        repeat (20) @(posedge clk_sys);
        rst_n <= 1'b1;
        supply_rise <= 1'b0;
    endtask : rst

    // Outputs lag the register by one more edge, so let two edges pass
    task automatic outs(input logic [3:0] exp);
        repeat (2) @(posedge clk_sys);
        #1 `CHK({pd_req, idle_req, baud_x2_en, serial_top_bit_view}, exp)
    endtask : outs

    // One-cycle pulse on an event input
    task automatic pulse(input logic wake);
        @(posedge clk_sys);
        irq_taken <= !wake;
        ext_level_wake <= wake;
        @(posedge clk_sys);
        irq_taken <= 1'b0;
        ext_level_wake <= 1'b0;
    endtask : pulse

    // Guard against a hang
    initial begin
        #200000;
        n_mismatch++;
        end_sim();
    end

    // Main sequence
    initial begin
        repeat (20) @(posedge clk_sys);
        rst_n <= 1'b1;
        supply_rise <= 1'b0;
        rd_chk(PCR_ADDR, PCR_RESET_VAL);
        outs(4'b0001);
        wr(PCR_ADDR, 8'hDF);
        rd_chk(PCR_ADDR, 8'hDF);
        outs(4'b1010);
        @(posedge clk_sys);
        serial_mode <= 2'h0;
        framing_error_flag <= 1'b1;
        outs(4'b1001);
        rst(1'b0);
        rd_chk(PCR_ADDR, 8'h10);
        wr(PCR_ADDR, 8'h00);
        rd_chk(PCR_ADDR, 8'h00);
        rst(1'b0);
        rd_chk(PCR_ADDR, 8'h00);
        rst(1'b1);
        rd_chk(PCR_ADDR, 8'h10);
        wr(PCR_ADDR, 8'h0D);
        outs(4'b0101);
        pulse(1'b0);
        rd_chk(PCR_ADDR, 8'h0C);
        wr(PCR_ADDR, 8'h03);
        pulse(1'b0);
        rd_chk(PCR_ADDR, 8'h02);
        outs(4'b1001);
        pulse(1'b1);
        rd_chk(PCR_ADDR, 8'h00);
        wr(PCR_ADDR, 8'h0C);
        pulse(1'b1);
        rd_chk(PCR_ADDR, 8'h0C);
        wr(8'h88, 8'hFF);
        rd_chk(8'h86, 8'h00);
        rd_chk(PCR_ADDR, 8'h0C);
        @(posedge clk_sys);
        serial_mode <= 2'h3;
        serial_mode_bit_zero <= 1'b0;
        wr(PCR_ADDR, 8'h80);
        outs(4'b0010);
        end_sim();
    end
endmodule : pcr_power_control_tb
